// ### sim/ipm_core_props.sv
// Assertions on the priority and power mode ports
`timescale 1ns/1ps
`include "ipm_params.svh"
`default_nettype none
module ipm_core_props #(parameter int NUM_SRC = 7) (
    input wire logic               i_core_clk,
    input wire logic               i_srst,
    input wire logic [7:0]         i_addr,
    input wire logic [7:0]         i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [7:0]         o_rdata,
    input wire logic [NUM_SRC-1:0] i_irq_req,
    input wire logic [NUM_SRC-1:0] i_irq_en,
    input wire logic               i_ext_irq_pin_a_n,
    input wire logic               i_ext_irq_pin_b_n,
    input wire logic               i_irq_ack,
    input wire logic               o_core_clk_en,
    input wire logic               o_osc_en,
    input wire logic               o_strobe_hold_high,
    input wire logic               o_port_hold,
    input wire logic               o_irq_valid
);
    wire pwr_wr = i_wr && i_addr == `IPM_ADDR_PWR_CTRL && o_core_clk_en;
    wire req_hit = |(i_irq_req & i_irq_en);
    wire pin_a = !i_ext_irq_pin_a_n && i_irq_en[0];
    wire pin_b = !i_ext_irq_pin_b_n && i_irq_en[2];
    // No enabled pin let go yet, so the exit must not finish
    wire held = (pin_a || pin_b) && (pin_a || !i_irq_en[0]) && (pin_b || !i_irq_en[2]);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    property p_rd_zero; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
    property p_bit7; $past(i_rd) |-> !o_rdata[7]; endproperty
    a_bit7: assert property (p_bit7) else $error("reserved bit read as one");
    property p_idle_in; pwr_wr && i_wdata[1:0] == 2'b01 && !req_hit |-> ##[1:2]
        (!o_core_clk_en && o_osc_en && o_strobe_hold_high && o_port_hold); endproperty
    a_idle_in: assert property (p_idle_in) else $error("idle entry wrong");
    property p_pd_in; pwr_wr && i_wdata[1] |-> ##[1:2] !o_osc_en && !o_core_clk_en; endproperty
    a_pd_in: assert property (p_pd_in) else $error("power-down entry wrong");
    property p_idle_out; o_strobe_hold_high && req_hit |-> ##[1:3] o_core_clk_en; endproperty
    a_idle_out: assert property (p_idle_out) else $error("idle not left");
    property p_pd_stay; !o_osc_en && !pin_a && !pin_b |=> !o_osc_en; endproperty
    a_pd_stay: assert property (p_pd_stay) else $error("stray wake");
    property p_pd_wake; !o_osc_en && (pin_a || pin_b) |=> o_osc_en; endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("no restart");
    property p_pd_held; o_osc_en && !o_core_clk_en && !o_strobe_hold_high && held |=>
        !o_core_clk_en; endproperty
    a_pd_held: assert property (p_pd_held) else $error("exit before release");
    property p_ack; i_irq_ack |=> !o_irq_valid; endproperty
    a_ack: assert property (p_ack) else $error("request kept after ack");
    c_idle: cover property (o_strobe_hold_high ##1 o_core_clk_en);
    c_wake: cover property (!o_osc_en ##1 o_osc_en);
    c_ack: cover property (o_irq_valid && i_irq_ack);
endmodule // ipm_core_props
bind ipm_core ipm_core_props #(.NUM_SRC(NUM_SRC)) ipm_core_props_i (.*);
`default_nettype wire

// ### sim/ipm_core_tb.sv
// Self-checking bench for the priority and power mode block
`timescale 1ns/1ps
`include "ipm_params.svh"
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module ipm_core_tb;
    logic       i_core_clk = '0, i_srst = '1, i_wr = '0, i_rd = '0, i_irq_ack = '0, rd_q = '0;
    logic [7:0] i_addr = '0, i_wdata = '0, hi, lo;
    logic [6:0] i_irq_req = '0, i_irq_en = '0;
    logic [1:0] low = '0;
    logic [5:0] best;
    logic [7:0] expq[$];
    int         miscompares = 0, checks_done = 0, seed = 32'hc06eaf14;
    wire logic  i_ext_irq_pin_a_n, i_ext_irq_pin_b_n, o_core_clk_en, o_osc_en, o_irq_valid;
    wire logic  o_strobe_hold_high, o_port_hold;
    wire logic [7:0] o_rdata;
    wire logic [2:0] o_irq_src;
    wire logic [1:0] o_irq_level;
    always #2 i_core_clk = !i_core_clk;
    ipm_core #(.OSC_STABLE_CYC(4)) ipm_core_i (.*);
    ipm_pin_model #(.HOLD(8)) ipm_pin_model_i (.i_clk(i_core_clk), .i_low(low),
        .o_pin_a_n(i_ext_irq_pin_a_n), .o_pin_b_n(i_ext_irq_pin_b_n));
    always @(posedge i_core_clk) begin
        if (rd_q) `CHK(o_rdata, expq.pop_front())
        rd_q <= i_rd;
    end
    // A read notes its expected byte; the monitor above checks it one cycle on
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge i_core_clk);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        if (!w) expq.push_back(d);
        @(posedge i_core_clk);
        i_wr <= '0;
        i_rd <= '0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_srst <= '0;
        bus(0, `IPM_ADDR_PRIO_HI, 8'h00);
        bus(0, `IPM_ADDR_PRIO_LO, 8'h00);
        bus(0, 8'h20, 8'h00);
        $display("reset values done");
        repeat (8) begin
            hi = 8'($random(seed)) & 8'h7f;
            lo = 8'($random(seed)) & 8'h7f;
            bus(1, `IPM_ADDR_PRIO_HI, hi);
            bus(1, `IPM_ADDR_PRIO_LO, lo);
            bus(0, `IPM_ADDR_PRIO_HI, hi & `IPM_PRIO_MASK);
            bus(0, `IPM_ADDR_PRIO_LO, lo & `IPM_PRIO_MASK);
            i_irq_req <= (7'($random(seed)) & 7'h7a) | 7'h08;
            i_irq_en <= 7'($random(seed)) | 7'h08;
            tick(3);
            best = '0;
            for (int i = 6; i >= 0; i--)
                if (i_irq_req[i] && i_irq_en[i] && (!best[5] || {hi[i], lo[i]} >= best[1:0]))
                    best = {1'b1, 3'(i), hi[i], lo[i]};
            `CHK({o_irq_valid, o_irq_src, o_irq_level}, best)
        end
        @(posedge i_core_clk);
        i_irq_ack <= '1;
        @(posedge i_core_clk);
        i_irq_ack <= '0;
        i_irq_req <= '0;
        #1 `CHK(o_irq_valid, 1'b0)
        $display("priority done");
        bus(1, `IPM_ADDR_PWR_CTRL, 8'h0d);
        tick(2);
        `CHK({o_core_clk_en, o_osc_en, o_strobe_hold_high, o_port_hold}, 4'h7)
        @(posedge i_core_clk);
        i_irq_req <= 7'h02;
        i_irq_en <= 7'h02;
        tick(4);
        `CHK(o_core_clk_en, 1'b1)
        bus(0, `IPM_ADDR_PWR_CTRL, 8'h0c);
        bus(0, `IPM_ADDR_PRIO_LO, lo & `IPM_PRIO_MASK);
        $display("idle done");
        i_irq_req <= '0;
        i_irq_en <= 7'h15;
        bus(1, `IPM_ADDR_PWR_CTRL, 8'h0f);
        tick(2);
        `CHK({o_core_clk_en, o_osc_en}, 2'b00)
        @(posedge i_core_clk);
        i_irq_req <= 7'h10;
        tick(4);
        `CHK(o_osc_en, 1'b0)
        @(posedge i_core_clk);
        i_irq_req <= '0;
        low <= 2'b01;
        @(posedge i_core_clk);
        low <= '0;
        tick(2);
        `CHK({o_core_clk_en, o_osc_en}, 2'b01)
        tick(14);
        `CHK(o_core_clk_en, 1'b1)
        bus(0, `IPM_ADDR_PWR_CTRL, 8'h0c);
        bus(0, `IPM_ADDR_PRIO_HI, hi & `IPM_PRIO_MASK);
        $display("power-down done");
        bus(1, `IPM_ADDR_PWR_CTRL, 8'h01);
        i_srst <= '1;
        repeat (6) @(posedge i_core_clk);
        i_srst <= '0;
        tick(1);
        `CHK(o_core_clk_en, 1'b1)
        bus(0, `IPM_ADDR_PRIO_LO, 8'h00);
        bus(0, `IPM_ADDR_PWR_CTRL, 8'h00);
        tick(2);
        $display("reset exit done");
        report_and_stop();
    end
endmodule // ipm_core_tb
`default_nettype wire

// ### sim/ipm_pin_model.sv
// External interrupt pins as driven from outside the device
`timescale 1ns/1ps
`default_nettype none
module ipm_pin_model #(parameter int HOLD = 8) (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_low,
    output logic            o_pin_a_n,
    output logic            o_pin_b_n
);
    logic [1:0] low_q = '0;
    int         held_q = 0;
    assign o_pin_a_n = !low_q[0]; // Pull-up level once released
    assign o_pin_b_n = !low_q[1];
    // Held low until the oscillator has had time to settle
    always_ff @(posedge i_clk) begin
        held_q <= (|low_q) ? held_q + 1 : 0;
        low_q <= i_low | ((held_q < HOLD) ? low_q : 2'b00);
    end
endmodule // ipm_pin_model
`default_nettype wire

// ### verilog/ipm_core.sv
// Interrupt priority registers and idle / power-down mode control
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "ipm_params.svh"
`default_nettype none

// Summary of operation
// - Low priority register holds low priority bit per source, bits 6..0.
// - High priority register holds matching high-order priority bits.
// - Code {high,low} gives four levels; higher level wins on coincidence.
// - Reset clears both priority registers.
// - Idle-setting write completes, then core executes nothing further.
// - In idle only the core clock is gated; peripherals keep running.
// - Core state is held unchanged during idle.
// - Ports hold levels in idle; address latch and store strobes held high.
// - Enabled interrupt during idle clears idle bit and is serviced.
// - After return, execution resumes after the idle-entering instruction.
// - Reset ends idle; two machine cycles of reset suffice.
// - Power-down stops the oscillator after the requesting instruction.
// - RAM and registers keep contents in power-down.
// - Power-down exits only on reset or external interrupt.
// - Only enabled external interrupts wake from power-down.
// - Low enabled pin restarts oscillator; exit completes when pin rises.
// - With both enabled, restart on either low; exit on first release.
// - With both waking, the higher priority one is serviced.
// - After return, execution continues after the power-down instruction.
// - Reset exit reinitialises registers; interrupt exit leaves them.
// - Idle with power-down uses power-down exit, clears both bits.
module ipm_core #(
    parameter int NUM_SRC        = `IPM_NUM_SRC,
    parameter int OSC_STABLE_CYC = `IPM_OSC_STABLE_CYC
) (
    input  wire logic               i_core_clk,
    input  wire logic               i_srst,
    input  wire logic [7:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [7:0]         o_rdata,
    input  wire logic [NUM_SRC-1:0] i_irq_req,
    input  wire logic [NUM_SRC-1:0] i_irq_en,
    input  wire logic               i_ext_irq_pin_a_n,
    input  wire logic               i_ext_irq_pin_b_n,
    input  wire logic               i_irq_ack,
    output logic                    o_core_clk_en,
    output logic                    o_osc_en,
    output logic                    o_strobe_hold_high,
    output logic                    o_port_hold,
    output logic                    o_irq_valid,
    output logic      [2:0]         o_irq_src,
    output logic      [1:0]         o_irq_level
);

    initial begin
        if (NUM_SRC != `IPM_NUM_SRC) begin
            $error("NUM_SRC must be 7");
        end
        if (NUM_SRC > 8) begin
            $error("NUM_SRC must fit the 3-bit source index");
        end
        if (OSC_STABLE_CYC < 1) begin
            $error("OSC_STABLE_CYC must be at least 1");
        end
        if (OSC_STABLE_CYC > 65535) begin
            $error("OSC_STABLE_CYC must fit a 16-bit settling counter");
        end
    end

    localparam int CW = $clog2(OSC_STABLE_CYC + 1);

    logic [7:0]         prio_lo_q;
    logic [7:0]         prio_lo_d;
    logic [7:0]         prio_hi_q;
    logic [7:0]         prio_hi_d;
    logic [7:0]         pwr_q;
    logic [7:0]         pwr_d;
    ipm_pkg::ipm_mode_t mode_q;
    ipm_pkg::ipm_mode_t mode_d;
    logic [CW-1:0]      stab_q;
    logic [CW-1:0]      stab_d;
    logic [7:0]         rdata_d;
    logic               ext_a_low_q;
    logic               ext_b_low_q;
    logic               sel_lo;
    logic               sel_hi;
    logic               sel_pwr;
    logic               ext_a_act;
    logic               ext_b_act;
    logic               any_low;
    logic               released;
    logic               stable;
    logic               pwr_wr;
    logic               req_idle;
    logic               req_pdown;
    logic               run_d;
    logic               idle_d;
    logic               osc_d;
    logic [7:0]         prio_lo_rd;
    logic [7:0]         prio_hi_rd;
    logic [7:0]         pwr_rd;

    assign sel_lo  = (i_addr == `IPM_ADDR_PRIO_LO);
    assign sel_hi  = (i_addr == `IPM_ADDR_PRIO_HI);
    assign sel_pwr = (i_addr == `IPM_ADDR_PWR_CTRL);

    // Named priority fields; bit 7 has no storage behind it and reads zero
    wire counter_array_prio_lo = prio_lo_q[`IPM_SRC_CNTARR];
    wire timer2_prio_lo        = prio_lo_q[`IPM_SRC_TMR2];
    wire serial_prio_lo        = prio_lo_q[`IPM_SRC_SERIAL];
    wire timer1_prio_lo        = prio_lo_q[`IPM_SRC_TMR1];
    wire ext_irq1_prio_lo      = prio_lo_q[`IPM_SRC_EXT1];
    wire timer0_prio_lo        = prio_lo_q[`IPM_SRC_TMR0];
    wire ext_irq0_prio_lo      = prio_lo_q[`IPM_SRC_EXT0];
    wire counter_array_prio_hi = prio_hi_q[`IPM_SRC_CNTARR];
    wire timer2_prio_hi        = prio_hi_q[`IPM_SRC_TMR2];
    wire serial_prio_hi        = prio_hi_q[`IPM_SRC_SERIAL];
    wire timer1_prio_hi        = prio_hi_q[`IPM_SRC_TMR1];
    wire ext_irq1_prio_hi      = prio_hi_q[`IPM_SRC_EXT1];
    wire timer0_prio_hi        = prio_hi_q[`IPM_SRC_TMR0];
    wire ext_irq0_prio_hi      = prio_hi_q[`IPM_SRC_EXT0];
    assign prio_lo_rd = {1'b0, counter_array_prio_lo, timer2_prio_lo, serial_prio_lo,
                         timer1_prio_lo, ext_irq1_prio_lo, timer0_prio_lo,
                         ext_irq0_prio_lo};
    assign prio_hi_rd = {1'b0, counter_array_prio_hi, timer2_prio_hi, serial_prio_hi,
                         timer1_prio_hi, ext_irq1_prio_hi, timer0_prio_hi,
                         ext_irq0_prio_hi};

    // Power control fields; the upper nibble is not stored
    wire idle_request_bit      = pwr_q[`IPM_BIT_IDLE];
    wire powerdown_request_bit = pwr_q[`IPM_BIT_PDOWN];
    wire general_flag_a        = pwr_q[`IPM_BIT_GFA];
    wire general_flag_b        = pwr_q[`IPM_BIT_GFB];
    assign pwr_rd = {4'h0, general_flag_b, general_flag_a,
                     powerdown_request_bit, idle_request_bit};

    // Per-source level and candidate search
    logic [1:0] lvl [NUM_SRC];
    logic [NUM_SRC-1:0] pend;
    assign pend = i_irq_req & i_irq_en;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_lvl
            assign lvl[g] = {prio_hi_q[g], prio_lo_q[g]};
        end
    endgenerate

    // Lowest index wins ties, so the loop runs downward with >= compare
    logic       best_v;
    logic [2:0] best_s;
    logic [1:0] best_l;
    always_comb begin
        best_v = 1'b0;
        best_s = 3'h0;
        best_l = 2'h0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (pend[k] && (!best_v || lvl[k] >= best_l)) begin
                best_v = 1'b1;
                best_s = 3'(k);
                best_l = lvl[k];
            end
        end
    end

    // Wake sources in power-down: enabled external pins only
    assign ext_a_act = i_irq_en[`IPM_SRC_EXT0] & ~i_ext_irq_pin_a_n;
    assign ext_b_act = i_irq_en[`IPM_SRC_EXT1] & ~i_ext_irq_pin_b_n;
    assign any_low   = ext_a_act | ext_b_act;
    // Exit completes once a pin that was held low is released
    assign released  = (ext_a_low_q & i_ext_irq_pin_a_n) |
                       (ext_b_low_q & i_ext_irq_pin_b_n);
    // Settling is counted in core clocks once a pin restarts the oscillator
    assign stable    = (stab_q == CW'(OSC_STABLE_CYC));

    assign pwr_wr    = i_wr & sel_pwr;
    assign req_idle  = pwr_wr & i_wdata[`IPM_BIT_IDLE];
    assign req_pdown = pwr_wr & i_wdata[`IPM_BIT_PDOWN];

    // Bit 7 is masked on write, so no write can ever set it
    always_comb begin
        prio_lo_d = prio_lo_q;
        prio_hi_d = prio_hi_q;
        if (i_wr && sel_lo) begin
            prio_lo_d = i_wdata & `IPM_PRIO_MASK;
        end
        if (i_wr && sel_hi) begin
            prio_hi_d = i_wdata & `IPM_PRIO_MASK;
        end
    end

    always_comb begin
        mode_d = mode_q;
        pwr_d  = pwr_q;
        stab_d = stab_q;
        case (mode_q)
            ipm_pkg::IPM_RUN: begin
                if (pwr_wr) begin
                    pwr_d = i_wdata & 8'h0f;
                end
                // The writing cycle completes; gating starts on the next edge
                if (req_pdown) begin
                    mode_d = ipm_pkg::IPM_PDOWN;
                end else if (req_idle) begin
                    mode_d = ipm_pkg::IPM_IDLE;
                end
            end
            ipm_pkg::IPM_IDLE: begin
                if (best_v) begin
                    pwr_d[`IPM_BIT_IDLE] = 1'b0;
                    mode_d = ipm_pkg::IPM_RUN;
                end
            end
            ipm_pkg::IPM_PDOWN: begin
                stab_d = '0;
                if (any_low) begin
                    mode_d = ipm_pkg::IPM_WAKE;
                end
            end
            ipm_pkg::IPM_WAKE: begin
                if (!stable) begin
                    stab_d = stab_q + CW'(1);
                end
                // Pin held too briefly: go back to sleep rather than half-exit
                if (!any_low && !(stable && released)) begin
                    mode_d = ipm_pkg::IPM_PDOWN;
                end else if (stable && released) begin
                    pwr_d[`IPM_BIT_IDLE]  = 1'b0;
                    pwr_d[`IPM_BIT_PDOWN] = 1'b0;
                    mode_d = ipm_pkg::IPM_RUN;
                end
            end
            default: mode_d = ipm_pkg::IPM_RUN;
        endcase
    end

    // Unmapped addresses and idle cycles read as zero
    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            if (sel_lo) begin
                rdata_d = prio_lo_rd;
            end else if (sel_hi) begin
                rdata_d = prio_hi_rd;
            end else if (sel_pwr) begin
                rdata_d = pwr_rd;
            end
        end
    end

    // Outputs follow the next mode so they turn on the same edge as the state
    assign run_d  = (mode_d == ipm_pkg::IPM_RUN);
    assign idle_d = (mode_d == ipm_pkg::IPM_IDLE);
    assign osc_d  = (mode_d != ipm_pkg::IPM_PDOWN);

    // Priority registers change only on a write or under reset, never on exit by pin
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            prio_lo_q <= `IPM_PRIO_RESET;
            prio_hi_q <= `IPM_PRIO_RESET;
        end else begin
            prio_lo_q <= prio_lo_d;
            prio_hi_q <= prio_hi_d;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pwr_q  <= `IPM_PWR_RESET;
            mode_q <= ipm_pkg::IPM_RUN;
        end else begin
            pwr_q  <= pwr_d;
            mode_q <= mode_d;
        end
    end

    // Oscillator settling count, only advanced while waking
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            stab_q <= '0;
        end else begin
            stab_q <= stab_d;
        end
    end

    // Pin history, so that a release is judged against the cycle before
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ext_a_low_q <= 1'b0;
            ext_b_low_q <= 1'b0;
        end else begin
            ext_a_low_q <= ext_a_act;
            ext_b_low_q <= ext_b_act;
        end
    end

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_d;
        end
    end

    // Gating comes from flip-flops so the core clock enable is glitch free
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_core_clk_en <= 1'b1;
            o_osc_en      <= 1'b1;
        end else begin
            o_core_clk_en <= run_d;
            o_osc_en      <= osc_d;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_strobe_hold_high <= 1'b0;
            o_port_hold        <= 1'b0;
        end else begin
            o_strobe_hold_high <= idle_d;
            o_port_hold        <= !run_d;
        end
    end

    // Acknowledge drops the request for a cycle so the core takes it once
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_irq_valid <= 1'b0;
        end else begin
            o_irq_valid <= best_v && !i_irq_ack;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_irq_src   <= 3'h0;
            o_irq_level <= 2'h0;
        end else begin
            o_irq_src   <= best_s;
            o_irq_level <= best_l;
        end
    end

endmodule // ipm_core
`default_nettype wire

// ### verilog/ipm_params.svh
// Constants for the interrupt priority and power mode block
`ifndef IPM_PARAMS_SVH
`define IPM_PARAMS_SVH
`define IPM_ADDR_PRIO_HI    8'hb7
`define IPM_ADDR_PRIO_LO    8'hb8
`define IPM_ADDR_PWR_CTRL   8'h87
`define IPM_PRIO_RESET      8'h00
`define IPM_PRIO_MASK       8'h7f
`define IPM_PWR_RESET       8'h00
`define IPM_BIT_IDLE        0
`define IPM_BIT_PDOWN       1
`define IPM_BIT_GFA         2
`define IPM_BIT_GFB         3
`define IPM_SRC_EXT0        0
`define IPM_SRC_EXT1        2
`define IPM_SRC_TMR0        1
`define IPM_SRC_TMR1        3
`define IPM_SRC_SERIAL      4
`define IPM_SRC_TMR2        5
`define IPM_SRC_CNTARR      6
`define IPM_NUM_SRC         7
`define IPM_RST_MIN_OSC     24
`define IPM_OSC_STABLE_CYC  16
`endif

// ### verilog/ipm_pkg.sv
// Types for the interrupt priority and power mode block
`default_nettype none
package ipm_pkg;
    typedef enum logic [1:0] {
        IPM_RUN,
        IPM_IDLE,
        IPM_PDOWN,
        IPM_WAKE
    } ipm_mode_t;
endpackage
`default_nettype wire
